// File: dv/art_pin_src.sv
// Purpose: external source on the timer input pin
// Assumes: pin idles low as if pulled down
// Notes: each request gives one high pulse of four cycles
`timescale 1ns/10ps
module art_pin_src (
  // clock
  input wire logic aclk,
  // request from the bench
  input wire logic pin_go,
  // driven pin
  output logic timer_input_pin
);
  logic [2:0] hold_q = 3'h0;
  // four cycles, above the two-cycle minimum, so both edges survive the synchroniser
  always_ff @(posedge aclk) begin
    if (pin_go) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  assign timer_input_pin = (hold_q != 3'h0);
endmodule : art_pin_src

// File: dv/art_timer_asserts.sv
// Purpose: port-level checks on the timer
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto art_timer after the module
`timescale 1ns/10ps
module art_timer_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and system
  input wire logic pwm_output_pin,
  input wire logic timer_irq,
  input wire logic stop_wake_ok
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them; read data upper bits stay zero
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // answer latency and refusal while busy
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response one cycle after take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data one cycle after take");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // wake permission only moves with a register write; past reset guards a short reset
  a_wake_on_write: assert property (
    $past(aresetn) && $changed(stop_wake_ok) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("stop wake changed without a write");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !pwm_output_pin && !timer_irq && !stop_wake_ok && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  // main scenarios
  c_pwm_high: cover property ($rose(pwm_output_pin));
  c_pwm_low: cover property ($fell(pwm_output_pin));
  c_irq: cover property ($rose(timer_irq));
endmodule : art_timer_asserts

bind art_timer art_timer_asserts u_art_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pwm_output_pin, .timer_irq, .stop_wake_ok
);

// File: dv/tb_top.sv
// Purpose: self-checking bench for the timer
// Assumes: bench is bus master, partner drives the input pin
// Notes: counter kept stopped wherever an exact value is expected, except the divide-by-128 reads in t_tap
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] MC = art_pkg::ADDR_MODE_CTRL;
  localparam logic [7:0] FS = art_pkg::ADDR_FLAG_STATUS;
  localparam logic [7:0] CE = art_pkg::ADDR_CLK_EDGE_CTRL;
  localparam logic [7:0] RC = art_pkg::ADDR_RELOAD_CAPTURE;
  localparam logic [7:0] CP = art_pkg::ADDR_COMPARE_VALUE;
  localparam logic [7:0] LD = art_pkg::ADDR_ON_THE_FLY_LOAD;
  localparam logic [7:0] WK = art_pkg::ADDR_WAKE_STATUS;
  // bench-driven inputs, defined from time zero
  logic aclk = 1'b0, aresetn = 1'b0, pin_go = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  // design outputs and results
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata;
  logic timer_input_pin, pwm_output_pin, pwm_output_enable, timer_irq, stop_wake_ok;
  logic [7:0] rv;
  int error_cnt = 0, checks_done = 0, cyc = 0;

  art_timer dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_input_pin, .pwm_output_pin, .pwm_output_enable,
    .timer_irq, .stop_wake_ok
  );
  art_pin_src src (.aclk, .pin_go, .timer_input_pin);

  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  // hang guard, far above the well under a thousand cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(n, rv, e);
  endtask : rc

  task automatic pulse();
    @(posedge aclk);
    pin_go <= 1'b1;
    @(posedge aclk);
    pin_go <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask : pulse

  task automatic wait_pwm(input logic lvl);
    for (int i = 0; i < 600 && pwm_output_pin !== lvl; i++) @(posedge aclk);
    chk("pwm_level", {7'h00, pwm_output_pin}, {7'h00, lvl});
  endtask : wait_pwm

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rc("reset_value", 8'(4 * i), 8'h00);
  endtask : t_reset

  task automatic t_bus();
    wr(8'h1C, 8'h5A);
    chk("unmapped_bresp", {6'h00, rr}, {6'h00, art_pkg::RESP_SLVERR});
    rc("unmapped_data", 8'h1C, 8'h00);
    chk("unmapped_rresp", {6'h00, rr}, {6'h00, art_pkg::RESP_SLVERR});
    wr(LD, 8'h5A);
    rc("fly_load", LD, 8'h5A);
    wr(RC, 8'hA0);
    wr(MC, 8'h80);
    rc("trigger_load", LD, 8'hA0);
    rc("trigger_reads_zero", MC, 8'h00);
    wr(CE, 8'h02);
    @(posedge aclk);
    chk("wake_pin", {7'h00, stop_wake_ok}, 8'h01);
    rc("wake_reg", WK, 8'h01);
    wr(CE, 8'h00);
    @(posedge aclk);
    chk("wake_int", {7'h00, stop_wake_ok}, 8'h00);
  endtask : t_bus

  // divide by 128: one tick needs 128 cycles, so about 100 and 200 cycles give 0 and 1
  task automatic t_tap();
    wr(LD, 8'h00);
    wr(CE, 8'hE0);
    wr(MC, 8'h40);
    repeat (100) @(posedge aclk);
    rc("tap_before", LD, 8'h00);
    repeat (100) @(posedge aclk);
    rc("tap_after", LD, 8'h01);
    wr(MC, 8'h00);
    repeat (300) @(posedge aclk);
    rc("frozen", LD, 8'h01);
  endtask : t_tap

  // 33 enabled edges at aclk/3 give 11 ticks; one of slack either way for bus timing
  task automatic t_clocks();
    wr(CE, 8'h01);
    wr(LD, 8'h00);
    wr(MC, 8'h40);
    repeat (30) @(posedge aclk);
    wr(MC, 8'h00);
    rd(LD);
    chk("div3_rate", {7'h00, (rv >= 8'h0A) && (rv <= 8'h0C)}, 8'h01);
    wr(CE, 8'h02);
    wr(LD, 8'h00);
    wr(MC, 8'h40);
    pulse();
    pulse();
    wr(MC, 8'h00);
    rc("pin_clock", LD, 8'h02);
  endtask : t_clocks

  task automatic t_pwm();
    wr(CE, 8'h00);
    wr(RC, 8'hF0);
    wr(CP, 8'hF8);
    wr(MC, 8'hEC);
    @(posedge aclk);
    chk("pwm_oe", {7'h00, pwm_output_enable}, 8'h01);
    wait_pwm(1'b1);
    wait_pwm(1'b0);
    wr(MC, 8'h2C);
    rd(LD);
    chk("reload_floor", {7'h00, rv >= 8'hF0}, 8'h01);
    rc("flags_set", FS, 8'h03);
    chk("irq_on", {7'h00, timer_irq}, 8'h01);
    wr(FS, 8'h06);
    rc("ovf_cleared", FS, 8'h02);
    wr(MC, 8'h24);
    repeat (3) @(posedge aclk);
    chk("irq_masked", {7'h00, timer_irq}, 8'h00);
    wr(FS, 8'h00);
    rc("flags_clear", FS, 8'h00);
  endtask : t_pwm

  task automatic t_capture();
    wr(CE, 8'h04);
    wr(LD, 8'h33);
    wr(MC, 8'h11);
    pulse();
    rc("capture_rise", RC, 8'h33);
    rc("edge_flag", FS, 8'h04);
    chk("edge_irq", {7'h00, timer_irq}, 8'h01);
    wr(FS, 8'h00);
    wr(CE, 8'h0C);
    wr(LD, 8'h44);
    pulse();
    rc("capture_fall", RC, 8'h44);
    wr(CE, 8'h08);
    wr(LD, 8'h55);
    pulse();
    rc("edge_disabled", RC, 8'h44);
  endtask : t_capture

  task automatic t_modes();
    wr(CE, 8'h04);
    wr(LD, 8'h77);
    wr(MC, 8'h02);
    pulse();
    rc("caprst_counter", LD, 8'h00);
    rc("caprst_capture", RC, 8'h77);
    wr(MC, 8'h03);
    wr(RC, 8'h99);
    wr(LD, 8'h10);
    pulse();
    rc("extload_counter", LD, 8'h99);
  endtask : t_modes

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_bus();
    t_tap();
    t_clocks();
    t_pwm();
    t_capture();
    t_modes();
    give_verdict();
  end
endmodule : tb_top

// File: hw/art_pkg.sv
// Purpose: constants for the auto-reload pwm/capture timer
// Assumes: axi4-lite byte addresses, one 32-bit word per register
// Notes: register bit layouts kept here so bench and design agree
package art_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAG_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLK_EDGE_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_VALUE = 8'h10;
  localparam logic [7:0] ADDR_ON_THE_FLY_LOAD = 8'h14;
  localparam logic [7:0] ADDR_WAKE_STATUS = 8'h18;
  // mode_control_reg fields
  localparam int MC_LOAD_TRIGGER = 7;
  localparam int MC_COUNT_ENABLE = 6;
  localparam int MC_WAVE_OE = 5;
  localparam int MC_EDGE_IE = 4;
  localparam int MC_CMP_IE = 3;
  localparam int MC_OVF_IE = 2;
  localparam int MC_MODE_HI = 1;
  localparam int MC_MODE_LO = 0;
  // flag_status_reg fields
  localparam int FS_EDGE = 2;
  localparam int FS_CMP = 1;
  localparam int FS_OVF = 0;
  // clock_edge_control_reg fields
  localparam int CE_PS_HI = 7;
  localparam int CE_PS_LO = 5;
  localparam int CE_EDGE_POL = 3;
  localparam int CE_EDGE_EN = 2;
  localparam int CE_CS_HI = 1;
  localparam int CE_CS_LO = 0;
  // reset values
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK_EDGE_CTRL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_PRESCALE = 7'h00;
  localparam logic [1:0] RST_DIV3 = 2'h0;
  localparam logic [1:0] DIV3_LAST = 2'h2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operating modes
  typedef enum logic [1:0] {
    ART_MODE_RELOAD = 2'b00,
    ART_MODE_CAPTURE = 2'b01,
    ART_MODE_CAPRST = 2'b10,
    ART_MODE_EXTLOAD = 2'b11
  } art_mode_t;
  // clock sources
  typedef enum logic [1:0] {
    ART_CLK_INT = 2'b00,
    ART_CLK_DIV3 = 2'b01,
    ART_CLK_PIN = 2'b10,
    ART_CLK_RSVD = 2'b11
  } art_clk_t;
endpackage : art_pkg

// File: hw/art_timer.sv
// Purpose: 8-bit auto-reload timer with pwm, capture and external load
// Assumes: aclk is the internal clock; pin inputs are asynchronous
// Notes: all slower rates are one-cycle enables, no derived clocks
`timescale 1ns/10ps
module art_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic timer_input_pin,
  output logic pwm_output_pin,
  output logic pwm_output_enable,
  // system
  output logic timer_irq,
  output logic stop_wake_ok
);
  // registers
  logic [7:0] mode_q;
  logic [7:0] cectl_q;
  logic [7:0] reload_q;
  logic [7:0] compare_q;
  logic [7:0] up_counter_q;
  logic [6:0] prescale_q;
  logic [1:0] div3_q;
  logic [2:0] flags_q;
  logic pwm_q;
  logic irq_q;
  logic wake_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  // axi state
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // field decode
  wire art_pkg::art_mode_t mode =
    art_pkg::art_mode_t'(mode_q[art_pkg::MC_MODE_HI:art_pkg::MC_MODE_LO]);
  wire art_pkg::art_clk_t clk_sel =
    art_pkg::art_clk_t'(cectl_q[art_pkg::CE_CS_HI:art_pkg::CE_CS_LO]);
  wire [2:0] tap_sel = cectl_q[art_pkg::CE_PS_HI:art_pkg::CE_PS_LO];
  wire count_en = mode_q[art_pkg::MC_COUNT_ENABLE];
  wire edge_en = cectl_q[art_pkg::CE_EDGE_EN];
  wire edge_fall = cectl_q[art_pkg::CE_EDGE_POL];

  // axi write: address and data taken in either order, then one response
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_hold_q || aw_fire;
  wire have_w = w_hold_q || w_fire;
  wire wr_go = have_aw && have_w && !bvalid_q;
  wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire wr_lane0 = wr_go && wr_strb[0];
  wire [7:0] wb = wr_data[7:0];
  wire wr_mode = wr_lane0 && (wr_addr == art_pkg::ADDR_MODE_CTRL);
  wire wr_flags = wr_lane0 && (wr_addr == art_pkg::ADDR_FLAG_STATUS);
  wire wr_cectl = wr_lane0 && (wr_addr == art_pkg::ADDR_CLK_EDGE_CTRL);
  wire wr_reload = wr_lane0 && (wr_addr == art_pkg::ADDR_RELOAD_CAPTURE);
  wire wr_compare = wr_lane0 && (wr_addr == art_pkg::ADDR_COMPARE_VALUE);
  wire wr_load = wr_lane0 && (wr_addr == art_pkg::ADDR_ON_THE_FLY_LOAD);
  wire wr_known = (wr_addr == art_pkg::ADDR_MODE_CTRL) ||
                  (wr_addr == art_pkg::ADDR_FLAG_STATUS) ||
                  (wr_addr == art_pkg::ADDR_CLK_EDGE_CTRL) ||
                  (wr_addr == art_pkg::ADDR_RELOAD_CAPTURE) ||
                  (wr_addr == art_pkg::ADDR_COMPARE_VALUE) ||
                  (wr_addr == art_pkg::ADDR_ON_THE_FLY_LOAD) ||
                  (wr_addr == art_pkg::ADDR_WAKE_STATUS);
  wire load_trigger = wr_mode && wb[art_pkg::MC_LOAD_TRIGGER];

  // clock source selection; pin clock edges come from the synchroniser
  wire pin_rise = pin_s2_q && !pin_s3_q;
  wire pin_fall = !pin_s2_q && pin_s3_q;
  wire src_tick = (clk_sel == art_pkg::ART_CLK_INT) ? 1'b1 :
                  (clk_sel == art_pkg::ART_CLK_DIV3) ? (div3_q == art_pkg::DIV3_LAST) :
                  (clk_sel == art_pkg::ART_CLK_PIN) ? pin_rise : 1'b0;

  // prescaler tap: tick when the low n bits roll over to zero
  function automatic logic tap_done(input logic [6:0] cnt, input logic [2:0] n);
    logic [7:0] mask;
    mask = (8'h01 << n) - 8'h01;
    tap_done = ((cnt & mask[6:0]) == mask[6:0]);
  endfunction : tap_done

  wire run_tick = count_en && src_tick;
  wire pre_out = run_tick && tap_done(prescale_q, tap_sel);
  wire overflow = pre_out && (up_counter_q == 8'hFF);
  wire edge_seen = edge_en && (edge_fall ? pin_fall : pin_rise);
  wire capture = edge_seen && ((mode == art_pkg::ART_MODE_CAPTURE) ||
                               (mode == art_pkg::ART_MODE_CAPRST));
  wire ext_load = edge_seen && (mode == art_pkg::ART_MODE_EXTLOAD);
  wire cap_reset = capture && (mode == art_pkg::ART_MODE_CAPRST);
  wire auto_reload = overflow && (mode == art_pkg::ART_MODE_RELOAD);

  // counter next value; software load wins over every hardware source
  wire any_load = wr_load || load_trigger || ext_load || cap_reset || auto_reload;
  wire [7:0] next_count = wr_load ? wb :
                          (load_trigger || ext_load || auto_reload) ? reload_q :
                          cap_reset ? art_pkg::RST_BYTE :
                          (up_counter_q + 8'h01);
  // match on the tick that lands on the compare value, so a compare of FF still has a low phase
  wire match = (next_count == compare_q);
  wire match_rise = match && pre_out;

  // flag clear mask: zero written clears, set beats clear
  wire [2:0] clr_mask = wr_flags ? ~wb[2:0] : 3'b000;
  wire [2:0] set_mask = {edge_seen, match_rise, overflow};
  wire [2:0] flags_d = (flags_q & ~clr_mask) | set_mask;
  wire [2:0] irq_en = {mode_q[art_pkg::MC_EDGE_IE], mode_q[art_pkg::MC_CMP_IE],
                       mode_q[art_pkg::MC_OVF_IE]};

  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= timer_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // divide-by-3 enable, always running so the rate is steady
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div3_q <= art_pkg::RST_DIV3;
    end else if (div3_q == art_pkg::DIV3_LAST) begin
      div3_q <= art_pkg::RST_DIV3;
    end else begin
      div3_q <= div3_q + 2'h1;
    end
  end

  // prescaler: cleared on any counter load, frozen when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_q <= art_pkg::RST_PRESCALE;
    end else if (any_load) begin
      prescale_q <= art_pkg::RST_PRESCALE;
    end else if (run_tick) begin
      prescale_q <= prescale_q + 7'h01;
    end
  end

  // up counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_counter_q <= art_pkg::RST_BYTE;
    end else if (any_load) begin
      up_counter_q <= next_count;
    end else if (pre_out) begin
      up_counter_q <= next_count;
    end
  end

  // control registers; load trigger bit is write-only and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= art_pkg::RST_MODE_CTRL;
      cectl_q <= art_pkg::RST_CLK_EDGE_CTRL;
      compare_q <= art_pkg::RST_BYTE;
    end else begin
      if (wr_mode) begin
        mode_q <= {1'b0, wb[6:0]};
      end
      if (wr_cectl) begin
        cectl_q <= {wb[7:5], 1'b0, wb[3:0]};
      end
      if (wr_compare) begin
        compare_q <= wb;
      end
    end
  end

  // reload/capture register: capture beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_q <= art_pkg::RST_BYTE;
    end else if (capture) begin
      reload_q <= up_counter_q;
    end else if (wr_reload) begin
      reload_q <= wb;
    end
  end

  // flags, pwm, irq and wake qualifier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 3'b000;
      pwm_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (overflow) begin
        pwm_q <= 1'b1;
      end else if (match_rise) begin
        pwm_q <= 1'b0;
      end
      irq_q <= |(flags_d & irq_en);
      wake_q <= (clk_sel == art_pkg::ART_CLK_PIN);
    end
  end

  // output pin follows pwm whether or not the waveform output is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_output_pin <= 1'b0;
      pwm_output_enable <= 1'b0;
    end else begin
      pwm_output_pin <= pwm_q;
      pwm_output_enable <= mode_q[art_pkg::MC_WAVE_OE];
    end
  end

  // axi write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= art_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_hold_q <= have_aw && !wr_go;
      w_hold_q <= have_w && !wr_go;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read mux; the load register reads the live counter
  wire [7:0] ar = s_axi_araddr;
  wire rd_known = (ar == art_pkg::ADDR_MODE_CTRL) || (ar == art_pkg::ADDR_FLAG_STATUS) ||
                  (ar == art_pkg::ADDR_CLK_EDGE_CTRL) || (ar == art_pkg::ADDR_RELOAD_CAPTURE) ||
                  (ar == art_pkg::ADDR_COMPARE_VALUE) || (ar == art_pkg::ADDR_ON_THE_FLY_LOAD) ||
                  (ar == art_pkg::ADDR_WAKE_STATUS);
  wire [7:0] rd_byte = (ar == art_pkg::ADDR_MODE_CTRL) ? mode_q :
                       (ar == art_pkg::ADDR_FLAG_STATUS) ? {5'b00000, flags_q} :
                       (ar == art_pkg::ADDR_CLK_EDGE_CTRL) ? cectl_q :
                       (ar == art_pkg::ADDR_RELOAD_CAPTURE) ? reload_q :
                       (ar == art_pkg::ADDR_COMPARE_VALUE) ? compare_q :
                       (ar == art_pkg::ADDR_ON_THE_FLY_LOAD) ? up_counter_q :
                       (ar == art_pkg::ADDR_WAKE_STATUS) ? {7'h00, wake_q} : 8'h00;
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= art_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_known ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ready strobes are registered so every output comes from a flop
  logic awready_q;
  logic wready_q;
  logic arready_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= !have_aw && !bvalid_q && !wr_go && !(awready_q && s_axi_awvalid);
      wready_q <= !have_w && !bvalid_q && !wr_go && !(wready_q && s_axi_wvalid);
      arready_q <= !rvalid_q && !ar_fire && !(arready_q && s_axi_arvalid);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign timer_irq = irq_q;
  assign stop_wake_ok = wake_q;
endmodule : art_timer
